// [logic/bdm_pkg.sv]
// Purpose: constants for the banked data map and peripheral input selectors
// Assumes: 12-bit banked data address, 32 banks of 128 bytes, five 8-pin ports
// Notes: selector codes are {port, pin}; codes past the last port select nothing
package bdm_pkg;
  // banked address layout
  localparam int ADDR_W = 12;
  localparam logic [6:0] CORE_END = 7'h0c;
  localparam logic [6:0] PCA_LAST = 7'h1f;
  localparam logic [6:0] GPR_FIRST = 7'h20;
  localparam logic [6:0] COMMON_FIRST = 7'h70;
  localparam int GPR_PER_BANK = 80;
  localparam int GPR_BANKS = 2;
  localparam int RAM_BYTES = GPR_BANKS * GPR_PER_BANK;
  localparam logic [ADDR_W-1:0] RAM_LIMIT = 12'(RAM_BYTES);
  localparam int COMMON_BYTES = 16;
  // pins
  localparam int PIN_COUNT = 40;
  localparam int CODE_W = 6;
  // selector register map
  localparam int SEL_COUNT = 24;
  localparam logic [ADDR_W-1:0] MOD3_LOW_CARRIER_IN_SEL_ADDR = 12'he27;
  localparam logic [ADDR_W-1:0] MOD3_HIGH_CARRIER_IN_SEL_ADDR = 12'he28;
  localparam logic [ADDR_W-1:0] MOD3_MODULATION_IN_SEL_ADDR = 12'he29;
  localparam logic [ADDR_W-1:0] MOD4_LOW_CARRIER_IN_SEL_ADDR = 12'he2a;
  localparam logic [ADDR_W-1:0] MOD4_HIGH_CARRIER_IN_SEL_ADDR = 12'he2b;
  localparam logic [ADDR_W-1:0] MOD4_MODULATION_IN_SEL_ADDR = 12'he2c;
  localparam logic [ADDR_W-1:0] RAMP1_RISE_IN_SEL_ADDR = 12'he2d;
  localparam logic [ADDR_W-1:0] RAMP1_FALL_IN_SEL_ADDR = 12'he2e;
  localparam logic [ADDR_W-1:0] RAMP2_RISE_IN_SEL_ADDR = 12'he2f;
  localparam logic [ADDR_W-1:0] RAMP2_FALL_IN_SEL_ADDR = 12'he30;
  localparam logic [ADDR_W-1:0] RAMP3_RISE_IN_SEL_ADDR = 12'he31;
  localparam logic [ADDR_W-1:0] RAMP3_FALL_IN_SEL_ADDR = 12'he32;
  localparam logic [ADDR_W-1:0] RAMP4_RISE_IN_SEL_ADDR = 12'he33;
  localparam logic [ADDR_W-1:0] RAMP4_FALL_IN_SEL_ADDR = 12'he34;
  localparam logic [ADDR_W-1:0] LOGIC_CELL_IN0_SEL_ADDR = 12'he35;
  localparam logic [ADDR_W-1:0] LOGIC_CELL_IN1_SEL_ADDR = 12'he36;
  localparam logic [ADDR_W-1:0] LOGIC_CELL_IN2_SEL_ADDR = 12'he37;
  localparam logic [ADDR_W-1:0] LOGIC_CELL_IN3_SEL_ADDR = 12'he38;
  localparam logic [ADDR_W-1:0] CONVERTER_TRIGGER_IN_SEL_ADDR = 12'he39;
  localparam logic [ADDR_W-1:0] SYNC_PORT_CLOCK_IN_SEL_ADDR = 12'he3a;
  localparam logic [ADDR_W-1:0] SYNC_PORT_DATA_IN_SEL_ADDR = 12'he3b;
  localparam logic [ADDR_W-1:0] SYNC_PORT_SELECT_IN_SEL_ADDR = 12'he3c;
  localparam logic [ADDR_W-1:0] SERIAL_RECEIVE_IN_SEL_ADDR = 12'he3d;
  localparam logic [ADDR_W-1:0] SERIAL_CLOCK_IN_SEL_ADDR = 12'he3e;
  localparam logic [4:0] SEL_BANK = MOD3_LOW_CARRIER_IN_SEL_ADDR[11:7];
  localparam logic [6:0] SEL_FIRST_OFF = MOD3_LOW_CARRIER_IN_SEL_ADDR[6:0];
  localparam logic [6:0] SEL_LAST_OFF = SERIAL_CLOCK_IN_SEL_ADDR[6:0];
  // power-on / brown-out values, index 0 is the lowest address
  localparam logic [SEL_COUNT-1:0][CODE_W-1:0] SEL_DEFAULTS = {
    6'h16, 6'h17, 6'h05, 6'h14, 6'h13, 6'h0c,
    6'h0f, 6'h0e, 6'h01, 6'h00, 6'h15, 6'h14,
    6'h15, 6'h14, 6'h12, 6'h11, 6'h05, 6'h04,
    6'h05, 6'h0b, 6'h0c, 6'h05, 6'h0b, 6'h0c
  };
  typedef enum logic [2:0] {HIT_NONE, HIT_CORE, HIT_PCA, HIT_RAM, HIT_SEL, HIT_COMMON} bdm_kind_e;
  typedef struct packed {
    bdm_kind_e kind;
    logic [7:0] idx;
  } bdm_hit_s;
endpackage : bdm_pkg

// [logic/bdm_data_map.sv]
// Purpose: banked data map with scratch RAM, common window and input selectors
// Assumes: core drives ADDR/WR_EN/RD_EN on CLK; reset controller names the reset kind
// Notes: RD_DATA answers one cycle after RD_EN; a read beside a write sees the old byte

module bdm_data_map
  import bdm_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  input wire logic POR_BOR,
  // data memory access
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic LINEAR,
  input wire logic WR_EN,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_EN,
  output logic [7:0] RD_DATA,
  output logic PCA_HIT,
  // pins and peripherals
  input wire logic [PIN_COUNT-1:0] PIN_IN,
  input wire logic [PIN_COUNT-1:0] PORT_LATCH,
  input wire logic [PIN_COUNT-1:0] OUT_SEL_ACTIVE,
  input wire logic [PIN_COUNT-1:0] PERIPH_OUT,
  output logic [SEL_COUNT-1:0] PERIPH_IN,
  output logic [PIN_COUNT-1:0] PIN_OUT
);

  typedef struct packed {
    logic [SEL_COUNT-1:0][CODE_W-1:0] sel;
    logic [RAM_BYTES-1:0][7:0] ram;
    logic [COMMON_BYTES-1:0][7:0] common;
    logic [PIN_COUNT-1:0] pin_s1;
    logic [PIN_COUNT-1:0] pin_s2;
    logic [7:0] rd_data;
    logic pca_hit;
    logic [SEL_COUNT-1:0] periph_in;
    logic [PIN_COUNT-1:0] pin_out;
  } bdm_state_s;

  bdm_state_s state_ff;
  bdm_state_s nxt_state;
  bdm_hit_s hit;
  logic [7:0] hit_idx;
  logic [CODE_W-1:0] pick_wr;

  // codes beyond the last port have no pin and give a quiet zero
  function automatic logic pick(input logic [PIN_COUNT-1:0] pins, input logic [CODE_W-1:0] code);
    logic v;
    v = 1'b0;
    if (int'(code) < PIN_COUNT) begin
      v = pins[code];
    end
    return v;
  endfunction : pick

  function automatic bdm_hit_s decode(input logic linear, input logic [ADDR_W-1:0] a);
    bdm_hit_s h;
    logic [4:0] bank;
    logic [6:0] off;
    h.kind = HIT_NONE;
    h.idx = 8'h00;
    bank = a[11:7];
    off = a[6:0];
    if (linear) begin
      // linear index walks bank 0 scratch then bank 1 scratch with no gaps
      if (a < RAM_LIMIT) begin
        h.kind = HIT_RAM;
        h.idx = a[7:0];
      end
    end else if (off < CORE_END) begin
      h.kind = HIT_CORE;
    end else if (off <= PCA_LAST) begin
      h.kind = HIT_PCA;
    end else if (off >= COMMON_FIRST) begin
      h.kind = HIT_COMMON;
      h.idx = {4'h0, off[3:0]};
    end else if (int'(bank) < GPR_BANKS) begin
      h.kind = HIT_RAM;
      h.idx = 8'(int'(bank) * GPR_PER_BANK) + {1'b0, off} - {1'b0, GPR_FIRST};
    end else if (bank == SEL_BANK && off >= SEL_FIRST_OFF && off <= SEL_LAST_OFF) begin
      h.kind = HIT_SEL;
      h.idx = {1'b0, off - SEL_FIRST_OFF};
    end
    return h;
  endfunction : decode

  assign hit = decode(LINEAR, ADDR);
  assign hit_idx = hit.idx;
  assign pick_wr = WR_DATA[CODE_W-1:0];

  always_comb begin
    nxt_state = state_ff;
    nxt_state.pin_s1 = PIN_IN;
    nxt_state.pin_s2 = state_ff.pin_s1;
    nxt_state.rd_data = 8'h00;
    nxt_state.pca_hit = 1'b0;
    if (RESET) begin
      // warm resets leave selectors alone so a running routing survives
      if (POR_BOR) begin
        nxt_state.sel = SEL_DEFAULTS;
      end
      nxt_state.pin_s1 = '0;
      nxt_state.pin_s2 = '0;
      nxt_state.periph_in = '0;
      nxt_state.pin_out = '0;
    end else begin
      if (RD_EN) begin
        unique case (hit.kind)
          HIT_RAM: nxt_state.rd_data = state_ff.ram[hit.idx];
          HIT_COMMON: nxt_state.rd_data = state_ff.common[hit.idx[3:0]];
          HIT_SEL: nxt_state.rd_data = {2'b00, state_ff.sel[hit.idx[4:0]]};
          HIT_PCA: nxt_state.pca_hit = 1'b1;
          HIT_CORE: nxt_state.rd_data = 8'h00;
          HIT_NONE: nxt_state.rd_data = 8'h00;
        endcase
      end
      if (WR_EN) begin
        unique case (hit.kind)
          HIT_RAM: nxt_state.ram[hit.idx] = WR_DATA;
          HIT_COMMON: nxt_state.common[hit.idx[3:0]] = WR_DATA;
          HIT_SEL: nxt_state.sel[hit.idx[4:0]] = pick_wr;
          HIT_PCA: nxt_state.pca_hit = 1'b1;
          HIT_CORE: nxt_state.pca_hit = nxt_state.pca_hit;
          HIT_NONE: nxt_state.pca_hit = nxt_state.pca_hit;
        endcase
      end
      // mux reads the selector value being written, so routing moves with the write
      for (int i = 0; i < SEL_COUNT; i++) begin
        nxt_state.periph_in[i] = pick(state_ff.pin_s2, nxt_state.sel[i]);
      end
      for (int p = 0; p < PIN_COUNT; p++) begin
        nxt_state.pin_out[p] = OUT_SEL_ACTIVE[p] ? PERIPH_OUT[p] : PORT_LATCH[p];
      end
    end
  end

  always_ff @(posedge CLK) begin
    state_ff <= nxt_state;
  end

  assign RD_DATA = state_ff.rd_data;
  assign PCA_HIT = state_ff.pca_hit;
  assign PERIPH_IN = state_ff.periph_in;
  assign PIN_OUT = state_ff.pin_out;

  // checks
  logic past_valid_ff;
  logic pick_wr_pin;
  logic wr_sel0;
  logic acc_pca;
  logic rd_none;
  logic rd_sel;
  logic por_pulse;
  logic warm_pulse;

  always_ff @(posedge CLK) begin
    past_valid_ff <= 1'b1;
  end

  assign pick_wr_pin = pick(state_ff.pin_s2, pick_wr);
  assign wr_sel0 = WR_EN && !LINEAR && ADDR == MOD3_LOW_CARRIER_IN_SEL_ADDR;
  assign acc_pca = (RD_EN || WR_EN) && hit.kind == HIT_PCA;
  assign rd_none = RD_EN && (hit.kind == HIT_NONE || hit.kind == HIT_CORE);
  assign rd_sel = RD_EN && hit.kind == HIT_SEL;
  assign por_pulse = RESET && POR_BOR;
  assign warm_pulse = RESET && !POR_BOR;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence s_ram_write;
    WR_EN && hit.kind == HIT_RAM;
  endsequence
  sequence s_ram_read_same;
    RD_EN && !WR_EN && hit.kind == HIT_RAM && hit_idx == $past(hit_idx);
  endsequence
  sequence s_common_write;
    WR_EN && hit.kind == HIT_COMMON;
  endsequence
  sequence s_common_read_same;
    RD_EN && !WR_EN && hit.kind == HIT_COMMON && hit_idx == $past(hit_idx);
  endsequence

  a_pca_decode: assert property (acc_pca |=> PCA_HIT)
    else $error("peripheral control area access not flagged");
  a_ram_alias: assert property (s_ram_write ##1 s_ram_read_same |=> RD_DATA == $past(WR_DATA, 2))
    else $error("scratch byte not returned through the other path");
  a_common_alias: assert property (s_common_write ##1 s_common_read_same
    |=> RD_DATA == $past(WR_DATA, 2))
    else $error("common byte differs between banks");
  a_unimpl_zero: assert property (rd_none |=> RD_DATA == 8'h00 && !PCA_HIT)
    else $error("unimplemented location read nonzero");
  a_sel_upper_zero: assert property (rd_sel |=> RD_DATA[7:6] == 2'b00)
    else $error("selector upper bits not zero");
  a_por_default: assert property (@(posedge CLK) disable iff (!past_valid_ff)
    por_pulse ##1 !RESET ##1 !RESET |-> PERIPH_IN[0] == pick(state_ff.pin_s2, SEL_DEFAULTS[0])
    || $past(WR_EN))
    else $error("selector did not take its default");
  a_warm_keep: assert property (@(posedge CLK) disable iff (!past_valid_ff)
    warm_pulse |=> $stable(state_ff.sel))
    else $error("warm reset disturbed a selector");
  a_mux_follow: assert property (wr_sel0 ##1 !RESET |-> PERIPH_IN[0] == $past(pick_wr_pin))
    else $error("peripheral input did not follow new selection");
  a_pin_default: assert property (!OUT_SEL_ACTIVE[0] ##1 !RESET
    |-> PIN_OUT[0] == $past(PORT_LATCH[0]))
    else $error("pin output not from port latch");

  // extra views of the decode, used only by the checks below
  logic wr_sel;
  logic rd_lin_far;
  logic off_common;
  logic off_pca;
  logic rd_core;
  logic lag_pick1;
  logic wr_none;
  assign wr_sel = WR_EN && hit.kind == HIT_SEL;
  assign rd_lin_far = RD_EN && LINEAR && ADDR >= RAM_LIMIT;
  assign off_common = !LINEAR && ADDR[6:0] >= COMMON_FIRST;
  assign off_pca = !LINEAR && ADDR[6:0] >= CORE_END && ADDR[6:0] <= PCA_LAST;
  assign rd_core = RD_EN && !LINEAR && ADDR[6:0] < CORE_END;
  // the routing seen one edge later is the one held by the selector now
  assign lag_pick1 = pick(state_ff.pin_s2, state_ff.sel[1]);
  assign wr_none = WR_EN && hit.kind == HIT_NONE;

  // selector write followed at once by a read of the same selector
  sequence s_sel_write;
    WR_EN && !RD_EN && hit.kind == HIT_SEL;
  endsequence
  sequence s_sel_read_same;
    RD_EN && !WR_EN && hit.kind == HIT_SEL && hit_idx == $past(hit_idx);
  endsequence

  // the whole selector bank is checked, not only the first entry
  a_por_load: assert property (@(posedge CLK) disable iff (!past_valid_ff)
    por_pulse |=> state_ff.sel == SEL_DEFAULTS)
    else $error("selector bank not at power-on defaults");
  a_sel_write: assert property (wr_sel
    |=> state_ff.sel[$past(hit_idx[4:0])] == $past(WR_DATA[CODE_W-1:0]))
    else $error("selector did not take the written code");
  a_sel_readback: assert property (s_sel_write ##1 s_sel_read_same
    |=> RD_DATA == {2'b00, $past(WR_DATA[CODE_W-1:0], 2)})
    else $error("selector read back differs from the write");
  // outputs must be quiet right after any reset cycle
  a_reset_quiet: assert property (@(posedge CLK) disable iff (!past_valid_ff)
    RESET |=> RD_DATA == 8'h00 && !PCA_HIT && PERIPH_IN == '0 && PIN_OUT == '0)
    else $error("outputs not cleared by reset");
  a_rd_idle: assert property (!RD_EN
    |=> RD_DATA == 8'h00)
    else $error("read data present with no read");
  a_linear_far: assert property (rd_lin_far
    |=> RD_DATA == 8'h00)
    else $error("linear index past scratch RAM read nonzero");
  a_core_zero: assert property (rd_core
    |=> RD_DATA == 8'h00 && !PCA_HIT)
    else $error("core register offset read nonzero here");
  a_pca_map: assert property (off_pca
    |-> hit.kind == HIT_PCA)
    else $error("control area offset decoded elsewhere");
  a_pca_quiet: assert property (!acc_pca
    |=> !PCA_HIT)
    else $error("control area flagged with no access");
  a_common_map: assert property (off_common
    |-> hit.kind == HIT_COMMON && hit_idx == {4'h0, ADDR[3:0]})
    else $error("common window offset decoded elsewhere");
  a_pin_periph: assert property (OUT_SEL_ACTIVE[0]
    |=> PIN_OUT[0] == $past(PERIPH_OUT[0]))
    else $error("programmed pin not driven by peripheral");
  a_sync_first: assert property (!RESET
    |=> state_ff.pin_s1 == $past(PIN_IN))
    else $error("first pin stage did not capture the pins");
  a_sync_second: assert property (!RESET
    |=> state_ff.pin_s2 == $past(state_ff.pin_s1))
    else $error("second pin stage did not follow the first");
  a_route_lag: assert property (!wr_sel
    |=> PERIPH_IN[1] == $past(lag_pick1))
    else $error("peripheral input not from its selected pin");
  // dropped writes must leave every storage element alone
  a_none_write: assert property (wr_none
    |=> $stable(state_ff.ram) && $stable(state_ff.common) && $stable(state_ff.sel))
    else $error("write to unimplemented location changed storage");
  a_read_keep: assert property (RD_EN && !WR_EN
    |=> $stable(state_ff.ram) && $stable(state_ff.common))
    else $error("read disturbed scratch or common storage");

endmodule : bdm_data_map

// [test/test_bdm_data_map.sv]
// Purpose: self-checking bench for the banked data map and input selectors
// Assumes: single-byte accesses driven on the falling edge, answer one cycle later
// Notes: selector defaults are kept in a table here so a wrong package value shows up
module test_bdm_data_map
  import bdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset, por_bor, linear, wr_en, rd_en, pca_hit, seen_hit;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wr_data, rd_data, seen;
  logic [PIN_COUNT-1:0] pin_in, port_latch, out_sel_active, periph_out, pin_out;
  logic [SEL_COUNT-1:0] periph_in, want_in;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;
  logic [5:0] dflt [SEL_COUNT] = '{6'h0c, 6'h0b, 6'h05, 6'h0c, 6'h0b, 6'h05, 6'h04, 6'h05,
    6'h11, 6'h12, 6'h14, 6'h15, 6'h14, 6'h15, 6'h00, 6'h01, 6'h0e, 6'h0f, 6'h0c, 6'h13,
    6'h14, 6'h05, 6'h17, 6'h16};
  logic [6:0] pca_off [4] = '{7'h0b, 7'h0c, 7'h1f, 7'h20};
  logic pca_want [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  bdm_data_map u_bdm_data_map (.CLK(clk), .RESET(reset), .POR_BOR(por_bor), .ADDR(addr),
    .LINEAR(linear), .WR_EN(wr_en), .WR_DATA(wr_data), .RD_EN(rd_en), .RD_DATA(rd_data),
    .PCA_HIT(pca_hit), .PIN_IN(pin_in), .PORT_LATCH(port_latch),
    .OUT_SEL_ACTIVE(out_sel_active), .PERIPH_OUT(periph_out), .PERIPH_IN(periph_in),
    .PIN_OUT(pin_out));

  always #25 clk = ~clk;

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // a hang still ends in the closing report, counted as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [39:0] got, input logic [39:0] want);
    checks++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, want, got);
    end
  endtask : chk

  task automatic rst(input logic pb);
    @(negedge clk);
    reset = 1'b1;
    por_bor = pb;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    por_bor = 1'b0;
  endtask : rst

  // strobe held across exactly one rising edge; the answer is taken one cycle on
  task automatic acc(input logic wr, input logic lin, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d);
    @(negedge clk);
    wr_en = wr;
    rd_en = !wr;
    linear = lin;
    addr = a;
    wr_data = d;
    @(negedge clk);
    seen = rd_data;
    seen_hit = pca_hit;
    wr_en = 1'b0;
    rd_en = 1'b0;
    linear = 1'b0;
  endtask : acc

  // write then read on the next edge, with no idle cycle between them
  task automatic wr_rd(input logic wl, input logic [ADDR_W-1:0] wa, input logic [7:0] d,
                       input logic rl, input logic [ADDR_W-1:0] ra);
    @(negedge clk);
    wr_en = 1'b1;
    linear = wl;
    addr = wa;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    linear = rl;
    addr = ra;
    @(negedge clk);
    seen = rd_data;
    rd_en = 1'b0;
    linear = 1'b0;
  endtask : wr_rd

  task automatic t_defaults;
    for (int i = 0; i < SEL_COUNT; i++) begin
      acc(1'b0, 1'b0, MOD3_LOW_CARRIER_IN_SEL_ADDR + 12'(i), 8'h00);
      chk("selector default", 40'(seen), {34'h0, dflt[i]});
    end
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_map;
    acc(1'b1, 1'b0, 12'h020, 8'ha5);
    acc(1'b1, 1'b0, 12'h0ef, 8'h3c);
    acc(1'b1, 1'b1, 12'd80, 8'h42);
    acc(1'b0, 1'b1, 12'd0, 8'h00);
    chk("linear 0", 40'(seen), 40'ha5);
    acc(1'b0, 1'b1, 12'd159, 8'h00);
    chk("linear 159", 40'(seen), 40'h3c);
    acc(1'b0, 1'b0, 12'h0a0, 8'h00);
    chk("bank1 0x20", 40'(seen), 40'h42);
    acc(1'b1, 1'b1, 12'd160, 8'h77);
    acc(1'b0, 1'b1, 12'd160, 8'h00);
    chk("linear 160", 40'(seen), 40'h0);
    acc(1'b1, 1'b0, 12'h070, 8'h5a);
    acc(1'b1, 1'b0, 12'he7f, 8'hc3);
    acc(1'b0, 1'b0, 12'hff0, 8'h00);
    chk("common 70", 40'(seen), 40'h5a);
    acc(1'b0, 1'b0, 12'h07f, 8'h00);
    chk("common 7f", 40'(seen), 40'hc3);
    acc(1'b1, 1'b0, 12'he3f, 8'h99);
    acc(1'b1, 1'b0, 12'h120, 8'h66);
    acc(1'b0, 1'b0, 12'he3f, 8'h00);
    chk("bank28 0x3f", 40'(seen), 40'h0);
    acc(1'b0, 1'b0, 12'h120, 8'h00);
    chk("bank2 0x20", 40'(seen), 40'h0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b0, {5'd5, pca_off[i]}, 8'h00);
      chk("control area hit", 40'(seen_hit), 40'(pca_want[i]));
    end
    wr_rd(1'b0, 12'h0a1, 8'h81, 1'b1, 12'd81);
    chk("banked then linear", 40'(seen), 40'h81);
    wr_rd(1'b0, 12'h570, 8'he1, 1'b0, 12'h0f0);
    chk("common across banks", 40'(seen), 40'he1);
    $display("test map done");
  endtask : t_map

  task automatic t_pins;
    port_latch = 40'h00ff00ff00;
    periph_out = 40'h0f0f0f0f0f;
    out_sel_active = 40'hffff080000;
    pin_in = 40'h0000a53c96;
    repeat (4) @(negedge clk);
    chk("pin out", pin_out, 40'h0f0f08ff00);
    for (int i = 0; i < SEL_COUNT; i++) begin
      want_in[i] = pin_in[dflt[i]];
    end
    chk("default routing", 40'(periph_in), 40'(want_in));
    pin_in = 40'h0000080000;
    repeat (4) @(negedge clk);
    acc(1'b1, 1'b0, MOD3_LOW_CARRIER_IN_SEL_ADDR, 8'h13);
    chk("new pin at once", 40'(periph_in[0]), 40'h1);
    pin_in = 40'h0;
    repeat (4) @(negedge clk);
    chk("follows pin", 40'(periph_in[0]), 40'h0);
    $display("test pins done");
  endtask : t_pins

  task automatic t_selectors;
    wr_rd(1'b0, SERIAL_CLOCK_IN_SEL_ADDR, 8'hc5, 1'b0, SERIAL_CLOCK_IN_SEL_ADDR);
    chk("selector readback", 40'(seen), 40'h05);
    for (int i = 0; i < SEL_COUNT; i++) begin
      acc(1'b1, 1'b0, MOD3_LOW_CARRIER_IN_SEL_ADDR + 12'(i), 8'hff);
    end
    pin_in = '1;
    repeat (4) @(negedge clk);
    chk("code past last port", 40'(periph_in), 40'h0);
    rst(1'b0);
    for (int i = 0; i < SEL_COUNT; i++) begin
      acc(1'b0, 1'b0, MOD3_LOW_CARRIER_IN_SEL_ADDR + 12'(i), 8'h00);
      chk("selector kept", 40'(seen), 40'h3f);
    end
    rst(1'b1);
    t_defaults();
    $display("test selectors done");
  endtask : t_selectors

  initial begin
    reset = 1'b1;
    por_bor = 1'b1;
    linear = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wr_data = '0;
    pin_in = '0;
    port_latch = '0;
    out_sel_active = '0;
    periph_out = '0;
    rst(1'b1);
    t_defaults();
    t_map();
    t_pins();
    t_selectors();
    wrap_up();
  end
endmodule : test_bdm_data_map
